// ==== rtl/hfcwa_host.sv ====
/*
  hfcwa_host: controller that runs single section accesses on the device
  management port, ordered by software over AXI4-Lite.
  assumes: device answers a read with rvalid one cycle after rd.
*/
`timescale 1ns/1ps
module hfcwa_host
  import hfcwa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  hfcwa_mgmt_if.host mgmt,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [1:0] {
    H_IDLE,
    H_DATA,
    H_WAIT
  } hfcwa_hstate_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wbuf;
    logic [31:0] cmd;
    logic [31:0] wdata;
    logic [31:0] result;
    logic busy;
    hfcwa_hstate_t st;
    logic [15:0] m_addr;
    logic m_wr;
    logic m_rd;
    logic [3:0] m_be;
    logic [31:0] m_wdata;
  } hfcwa_host_state_t;

  hfcwa_host_state_t s_reg;
  hfcwa_host_state_t s_next;

  always_comb begin
    logic [1:0] op;
    logic [7:0] word;
    logic [2:0] seq;
    op = s_reg.cmd[CMD_OP_LSB +: 2];
    word = s_reg.cmd[CMD_WORD_LSB +: 8];
    seq = s_reg.cmd[CMD_SEQ_LSB +: 3];
    s_next = s_reg;
    s_next.m_wr = 1'b0;
    s_next.m_rd = 1'b0;

    // axi write: address and data in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wbuf = s_axi_wdata;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = 2'h0;
      case (s_reg.awaddr)
        HOST_CMD_OFF: begin
          if (!s_reg.busy) begin
            s_next.cmd = s_reg.wbuf;
            s_next.busy = 1'b1;
          end
        end
        HOST_WDATA_OFF: s_next.wdata = s_reg.wbuf;
        HOST_RDATA_OFF: s_next.bresp = 2'h0;
        HOST_STATUS_OFF: s_next.bresp = 2'h0;
        default: s_next.bresp = 2'h2;
      endcase
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;

    // axi read
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = 2'h0;
      case (s_axi_araddr)
        HOST_CMD_OFF: s_next.rdata = s_reg.cmd;
        HOST_WDATA_OFF: s_next.rdata = s_reg.wdata;
        HOST_RDATA_OFF: s_next.rdata = s_reg.result;
        HOST_STATUS_OFF: s_next.rdata = {31'h0000_0000, s_reg.busy};
        default: begin
          s_next.rdata = REG_RESET;
          s_next.rresp = 2'h2;
        end
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    // management sequencer
    case (s_reg.st)
      H_IDLE: begin
        if (s_reg.busy) begin
          s_next.m_wr = 1'b1;
          s_next.m_wdata = REG_RESET;
          case (op)
            OP_RX_READ: begin
              s_next.m_addr = DEV_IDX_ADDR;
              s_next.m_be = 4'h3;
              s_next.m_wdata[IDX_RXX_LSB +: 8] = word;
              s_next.m_wdata[IDX_RXSEQ_LSB +: 3] = seq;
              s_next.st = H_DATA;
            end
            OP_TX_WRITE: begin
              s_next.m_addr = DEV_IDX_ADDR;
              s_next.m_be = 4'hc;
              s_next.m_wdata[IDX_TXX_LSB +: 8] = word;
              s_next.m_wdata[IDX_TXSEQ_LSB +: 3] = seq;
              s_next.st = H_DATA;
            end
            OP_TX_INSERT: begin
              s_next.m_addr = DEV_IDX_ADDR;
              s_next.m_be = 4'hc;
              s_next.m_wdata[IDX_TXX_LSB +: 8] = word;
              s_next.m_wdata[IDX_TXSEQ_LSB +: 3] = seq;
              s_next.m_wdata[IDX_TXINS_BIT] = 1'b1;
              s_next.busy = 1'b0;
            end
            default: begin
              s_next.m_addr = DEV_L1_ADDR;
              s_next.m_be = 4'hf;
              s_next.m_wdata = s_reg.wdata;
              s_next.busy = 1'b0;
            end
          endcase
        end
      end
      H_DATA: begin
        if (op == OP_RX_READ) begin
          s_next.m_rd = 1'b1;
          s_next.m_addr = DEV_RXDATA_ADDR;
          s_next.st = H_WAIT;
        end else begin
          s_next.m_wr = 1'b1;
          s_next.m_addr = DEV_TXDATA_ADDR;
          s_next.m_be = 4'hf;
          s_next.m_wdata = s_reg.wdata;
          s_next.busy = 1'b0;
          s_next.st = H_IDLE;
        end
      end
      H_WAIT: begin
        if (mgmt.rvalid) begin
          s_next.result = mgmt.rdata;
          s_next.busy = 1'b0;
          s_next.st = H_IDLE;
        end
      end
      default: s_next.st = H_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = s_reg.rdata;
  assign mgmt.addr = s_reg.m_addr;
  assign mgmt.wr = s_reg.m_wr;
  assign mgmt.rd = s_reg.m_rd;
  assign mgmt.be = s_reg.m_be;
  assign mgmt.wdata = s_reg.m_wdata;

endmodule

// ==== rtl/hfcwa_pkg.sv ====
/*
  hfcwa_pkg: constants and types shared by the control-word access device
  end and its host controller.
  assumes: one clock, 32-bit management data, word-addressed device port.
*/
package hfcwa_pkg;

  localparam int CW_NUM = 256;
  localparam int CW_BYTES = 17;
  localparam int CW_W = CW_BYTES * 8;
  localparam int SUBCH_NUM = 64;
  localparam int SEC_NUM = 5;

  // device register word addresses
  localparam logic [15:0] DEV_IDX_ADDR = 16'h0000;
  localparam logic [15:0] DEV_RXDATA_ADDR = 16'h0001;
  localparam logic [15:0] DEV_TXDATA_ADDR = 16'h0002;
  localparam logic [15:0] DEV_L1_ADDR = 16'h0003;

  // index register fields
  localparam int IDX_RXX_LSB = 0;
  localparam int IDX_RXSEQ_LSB = 8;
  localparam int IDX_TXX_LSB = 16;
  localparam int IDX_TXSEQ_LSB = 24;
  localparam int IDX_TXINS_BIT = 31;

  // layer1_config_reg fields
  localparam int L1_INSEN_BIT = 0;
  localparam int L1_RATE_LSB = 8;

  // host controller register byte offsets
  localparam logic [3:0] HOST_CMD_OFF = 4'h0;
  localparam logic [3:0] HOST_WDATA_OFF = 4'h4;
  localparam logic [3:0] HOST_RDATA_OFF = 4'h8;
  localparam logic [3:0] HOST_STATUS_OFF = 4'hc;

  // host command fields and operations
  localparam int CMD_WORD_LSB = 0;
  localparam int CMD_SEQ_LSB = 8;
  localparam int CMD_OP_LSB = 12;
  localparam logic [1:0] OP_RX_READ = 2'h0;
  localparam logic [1:0] OP_TX_WRITE = 2'h1;
  localparam logic [1:0] OP_TX_INSERT = 2'h2;
  localparam logic [1:0] OP_L1_WRITE = 2'h3;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    RATE_0614,
    RATE_1228,
    RATE_2457,
    RATE_3072,
    RATE_4915,
    RATE_6144,
    RATE_8110,
    RATE_9830,
    RATE_10137
  } hfcwa_rate_t;

endpackage

// ==== rtl/hfcwa_mgmt_if.sv ====
/*
  hfcwa_mgmt_if: management port between host controller and device end.
  assumes: both ends share aclk; read data answers one cycle after rd.
*/
`timescale 1ns/1ps
interface hfcwa_mgmt_if;
  logic [15:0] addr;
  logic wr;
  logic rd;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;

  modport dev (
    input addr,
    input wr,
    input rd,
    input be,
    input wdata,
    output rdata,
    output rvalid
  );

  modport host (
    output addr,
    output wr,
    output rd,
    output be,
    output wdata,
    input rdata,
    input rvalid
  );
endinterface

// ==== rtl/hfcwa_device.sv ====
/*
  hfcwa_device: hyperframe control-word tables reached through a
  sectioned index/data register window, plus frame-side table ports.
  assumes: frame-side inputs and line_rate are on aclk; the host waits
  one cycle between index write and data access.
*/
// Overview of operation
// - all 256 rx words readable, all 256 tx words readable and writable
// - word = subchannel plus 64 times position
// - index holds separate rx and tx word fields
// - each data access moves one 32-bit section
// - lowest rate: one byte in [31:24]
// - 1.2288: bytes 0,1 in upper half
// - 3.072: four bytes, then byte 4 high
// - populated sections follow line rate table
// - receive table returns latest received copy
// - host writes index, reads next cycle
// - host steps section with rising rate
// - section 4 only at 10.1376
// - tx words written section by section
// - register path for non-critical timing only
// - tx entry has word plus insert enable
// - global enable gates frame insertion
`timescale 1ns/1ps
module hfcwa_device
  import hfcwa_pkg::*;
#(
  parameter int NUM_WORDS = CW_NUM
) (
  input wire logic aclk,
  input wire logic aresetn,
  hfcwa_mgmt_if.dev mgmt,
  input wire hfcwa_rate_t line_rate,
  input wire logic rx_cw_valid,
  input wire logic [7:0] rx_cw_num,
  input wire logic [CW_W-1:0] rx_cw_data,
  input wire logic [7:0] tx_cw_num,
  output logic [CW_W-1:0] tx_cw_data,
  output logic tx_cw_insert
);

  if (NUM_WORDS < 1 || NUM_WORDS > CW_NUM) begin : g_chk
    $error("NUM_WORDS must lie in 1..256");
  end

  typedef struct packed {
    logic [7:0] rx_x;
    logic [2:0] rx_seq;
    logic [7:0] tx_x;
    logic [2:0] tx_seq;
    logic insert_en;
    logic [NUM_WORDS-1:0][CW_W-1:0] rx_tab;
    logic [NUM_WORDS-1:0][CW_W-1:0] tx_tab;
    logic [NUM_WORDS-1:0] tx_en;
    logic [31:0] rdata;
    logic rvalid;
    logic [CW_W-1:0] tx_cw_data;
    logic tx_cw_insert;
  } hfcwa_dev_state_t;

  hfcwa_dev_state_t s_reg;
  hfcwa_dev_state_t s_next;

  // number of populated control-word bytes per line rate
  function automatic int unsigned rate_bytes(input hfcwa_rate_t r);
    int unsigned n;
    n = 0;
    case (r)
      RATE_0614: n = 1;
      RATE_1228: n = 2;
      RATE_2457: n = 4;
      RATE_3072: n = 5;
      RATE_4915: n = 8;
      RATE_6144: n = 10;
      RATE_8110: n = 16;
      RATE_9830: n = 16;
      RATE_10137: n = 17;
      default: n = 0;
    endcase
    return n;
  endfunction

  // byte 4*seq+i of the word lands in lane 3-i, first byte highest
  function automatic logic [31:0] sec_get(
    input logic [CW_W-1:0] w,
    input logic [2:0] seq,
    input hfcwa_rate_t r
  );
    logic [31:0] v;
    int unsigned k;
    int unsigned n;
    v = '0;
    n = rate_bytes(r);
    for (int i = 0; i < 4; i++) begin
      k = 32'(seq) * 4 + 32'(i);
      if (k < n) begin
        v[31-8*i -: 8] = w[8*k +: 8];
      end
    end
    return v;
  endfunction

  function automatic logic [CW_W-1:0] sec_put(
    input logic [CW_W-1:0] w,
    input logic [2:0] seq,
    input logic [31:0] d,
    input logic [3:0] be,
    input hfcwa_rate_t r
  );
    logic [CW_W-1:0] v;
    int unsigned k;
    int unsigned n;
    v = w;
    n = rate_bytes(r);
    for (int i = 0; i < 4; i++) begin
      k = 32'(seq) * 4 + 32'(i);
      if (k < n && be[3-i]) begin
        v[8*k +: 8] = d[31-8*i -: 8];
      end
    end
    return v;
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;

    // frame side: latest received copy overwrites the entry
    if (rx_cw_valid && 32'(rx_cw_num) < NUM_WORDS) begin
      s_next.rx_tab[rx_cw_num] = rx_cw_data;
    end

    // frame side: entry data goes out for words below NUM_WORDS, else zeros; insert flag only when both enables set
    if (32'(tx_cw_num) < NUM_WORDS) begin
      s_next.tx_cw_data = s_reg.tx_tab[tx_cw_num];
      s_next.tx_cw_insert = s_reg.insert_en & s_reg.tx_en[tx_cw_num];
    end else begin
      s_next.tx_cw_data = '0;
      s_next.tx_cw_insert = 1'b0;
    end

    // register writes
    if (mgmt.wr) begin
      case (mgmt.addr)
        DEV_IDX_ADDR: begin
          if (mgmt.be[0]) begin
            s_next.rx_x = mgmt.wdata[IDX_RXX_LSB +: 8];
          end
          if (mgmt.be[1]) begin
            s_next.rx_seq = mgmt.wdata[IDX_RXSEQ_LSB +: 3];
          end
          if (mgmt.be[2]) begin
            s_next.tx_x = mgmt.wdata[IDX_TXX_LSB +: 8];
          end
          if (mgmt.be[3]) begin
            s_next.tx_seq = mgmt.wdata[IDX_TXSEQ_LSB +: 3];
            if (32'(s_next.tx_x) < NUM_WORDS) begin
              s_next.tx_en[s_next.tx_x] = mgmt.wdata[IDX_TXINS_BIT];
            end
          end
        end
        DEV_TXDATA_ADDR: begin
          if (32'(s_reg.tx_x) < NUM_WORDS) begin
            s_next.tx_tab[s_reg.tx_x] = sec_put(s_reg.tx_tab[s_reg.tx_x], s_reg.tx_seq,
              mgmt.wdata, mgmt.be, line_rate);
          end
        end
        DEV_L1_ADDR: begin
          if (mgmt.be[0]) begin
            s_next.insert_en = mgmt.wdata[L1_INSEN_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // register reads, answered one cycle later
    if (mgmt.rd) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = '0;
      case (mgmt.addr)
        DEV_IDX_ADDR: begin
          s_next.rdata[IDX_RXX_LSB +: 8] = s_reg.rx_x;
          s_next.rdata[IDX_RXSEQ_LSB +: 3] = s_reg.rx_seq;
          s_next.rdata[IDX_TXX_LSB +: 8] = s_reg.tx_x;
          s_next.rdata[IDX_TXSEQ_LSB +: 3] = s_reg.tx_seq;
          if (32'(s_reg.tx_x) < NUM_WORDS) begin
            s_next.rdata[IDX_TXINS_BIT] = s_reg.tx_en[s_reg.tx_x];
          end
        end
        DEV_RXDATA_ADDR: begin
          if (32'(s_reg.rx_x) < NUM_WORDS) begin
            s_next.rdata = sec_get(s_reg.rx_tab[s_reg.rx_x], s_reg.rx_seq, line_rate);
          end
        end
        DEV_TXDATA_ADDR: begin
          if (32'(s_reg.tx_x) < NUM_WORDS) begin
            s_next.rdata = sec_get(s_reg.tx_tab[s_reg.tx_x], s_reg.tx_seq, line_rate);
          end
        end
        DEV_L1_ADDR: begin
          s_next.rdata[L1_INSEN_BIT] = s_reg.insert_en;
          s_next.rdata[L1_RATE_LSB +: 4] = line_rate;
        end
        default: begin
          s_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mgmt.rdata = s_reg.rdata;
  assign mgmt.rvalid = s_reg.rvalid;
  assign tx_cw_data = s_reg.tx_cw_data;
  assign tx_cw_insert = s_reg.tx_cw_insert;

endmodule

// ==== bench/hfcwa_chk.sv ====
/*
  hfcwa_chk: timing checks on the management port between host and device.
  assumes: instantiated beside the interface, aclk with sync active-low reset.
*/
`timescale 1ns/1ps
module hfcwa_chk
  import hfcwa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  logic [2:0] seq_reg;
  logic [15:0] raddr_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg <= 3'h0;
      raddr_reg <= 16'h0000;
    end else begin
      if (wr && addr == DEV_IDX_ADDR && be[1]) begin
        seq_reg <= wdata[IDX_RXSEQ_LSB +: 3];
      end
      if (rd) begin
        raddr_reg <= addr;
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_idx_rx;
    wr && addr == DEV_IDX_ADDR && be == 4'h3;
  endsequence
  sequence s_rx_read;
    rd && addr == DEV_RXDATA_ADDR ##1 rvalid;
  endsequence
  a_rx_next_cycle: assert property (s_idx_rx |=> s_rx_read)
    else $error("rx data read does not follow index write");
  a_rd_answer: assert property (rd |=> rvalid)
    else $error("read without answer");
  a_rvalid_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  a_rd_pulse: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  a_rdata_stands: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without read");
  a_sec4_low: assert property (rvalid && raddr_reg == DEV_RXDATA_ADDR && seq_reg == 3'h4 |-> rdata[23:0] == 24'h0)
    else $error("fifth section low bits not zero");
  a_sec_empty: assert property (rvalid && raddr_reg == DEV_RXDATA_ADDR && seq_reg > 3'h4 |-> rdata == 32'h0)
    else $error("section beyond four not zero");
  a_txdata_full: assert property (wr && addr == DEV_TXDATA_ADDR |-> be == 4'hf)
    else $error("tx section write not full word");
endmodule

// ==== bench/hyperframe_ctrl_word_access_bench.sv ====
/*
  bench: host and device joined by the interface, driven over AXI4-Lite.
  assumes: hfcwa_pkg, interface, both design ends and checker compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module hyperframe_ctrl_word_access_bench
  import hfcwa_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rx_cw_valid;
  logic awready, wready, bvalid, arready, rvalid_s, tx_cw_insert;
  logic [3:0] awaddr, araddr, wstrb;
  logic [1:0] bresp, rresp, rresp_seen;
  logic [31:0] wdata_s, rdata_s;
  logic [7:0] rx_cw_num, tx_cw_num;
  logic [CW_W-1:0] rx_cw_data, tx_cw_data;
  hfcwa_rate_t line_rate;
  int mismatches, n_compared, cyc;
  int nbytes [9] = '{1, 2, 4, 5, 8, 10, 16, 16, 17};
  hfcwa_mgmt_if hfcwa_mgmt_if_inst ();
  hfcwa_device #(.NUM_WORDS(CW_NUM)) hfcwa_device_inst (.aclk(aclk), .aresetn(aresetn),
    .mgmt(hfcwa_mgmt_if_inst), .line_rate(line_rate), .rx_cw_valid(rx_cw_valid), .rx_cw_num(rx_cw_num),
    .rx_cw_data(rx_cw_data), .tx_cw_num(tx_cw_num), .tx_cw_data(tx_cw_data), .tx_cw_insert(tx_cw_insert));
  hfcwa_host hfcwa_host_inst (.aclk(aclk), .aresetn(aresetn), .mgmt(hfcwa_mgmt_if_inst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata_s),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata_s), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid_s),
    .s_axi_rready(rready));
  hfcwa_chk hfcwa_chk_inst (.aclk(aclk), .aresetn(aresetn), .addr(hfcwa_mgmt_if_inst.addr),
    .wr(hfcwa_mgmt_if_inst.wr), .rd(hfcwa_mgmt_if_inst.rd), .be(hfcwa_mgmt_if_inst.be),
    .wdata(hfcwa_mgmt_if_inst.wdata), .rdata(hfcwa_mgmt_if_inst.rdata), .rvalid(hfcwa_mgmt_if_inst.rvalid));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic results;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata_s <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    `CHK(bresp, 2'h0)
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid_s && rready));
    rready <= 1'b0;
    d = rdata_s;
    rresp_seen = rresp;
  endtask
  task automatic run_op(input logic [1:0] op, input logic [7:0] w, input logic [2:0] s);
    logic [31:0] st;
    axi_wr(HOST_CMD_OFF, {18'h0, op, 1'b0, s, w});
    st = 32'h1;
    for (int i = 0; i < 20 && st[0] !== 1'b0; i++) axi_rd(HOST_STATUS_OFF, st);
    `CHK(st[0], 1'b0)
  endtask
  function automatic logic [CW_W-1:0] pat(input logic [7:0] base);
    for (int k = 0; k < CW_BYTES; k++) pat[8*k +: 8] = base ^ 8'(k * 37 + 1);
  endfunction
  function automatic logic [31:0] exp_sec(input logic [CW_W-1:0] cw, input int nb, input int s);
    exp_sec = 32'h0;
    for (int i = 0; i < 4; i++) if (4 * s + i < nb) exp_sec[31-8*i -: 8] = cw[8*(4*s+i) +: 8];
  endfunction
  task automatic t_reset;
    logic [31:0] d;
    axi_rd(HOST_RDATA_OFF, d);
    `CHK(d, 32'h0)
    `CHK(rresp_seen, 2'h0)
    axi_rd(4'h1, d);
    `CHK(rresp_seen, 2'h2)
    `CHK(d, 32'h0)
  endtask
  task automatic t_rx_rates;
    logic [31:0] d;
    logic [7:0] x;
    for (int r = 0; r < 9; r++) begin
      x = 8'(16 + 64 * (r % 4));
      @(posedge aclk);
      line_rate <= hfcwa_rate_t'(r);
      rx_cw_num <= x;
      rx_cw_data <= pat(8'(r));
      rx_cw_valid <= 1'b1;
      @(posedge aclk);
      rx_cw_data <= pat(8'(r + 100));
      @(posedge aclk);
      rx_cw_valid <= 1'b0;
      for (int s = 0; s < 6; s++) begin
        run_op(OP_RX_READ, x, 3'(s));
        axi_rd(HOST_RDATA_OFF, d);
        `CHK(rresp_seen, 2'h0)
        `CHK(d, exp_sec(pat(8'(r + 100)), nbytes[r], s))
      end
    end
  endtask
  task automatic t_tx;
    @(posedge aclk);
    line_rate <= RATE_3072;
    tx_cw_num <= 8'd200;
    axi_wr(HOST_WDATA_OFF, 32'h11223344);
    run_op(OP_TX_WRITE, 8'd200, 3'h0);
    axi_wr(HOST_WDATA_OFF, 32'haabbccdd);
    run_op(OP_TX_WRITE, 8'd200, 3'h1);
    run_op(OP_TX_INSERT, 8'd200, 3'h0);
    @(posedge aclk);
    `CHK(tx_cw_data, 136'haa44332211)
    `CHK(tx_cw_insert, 1'b0)
    axi_wr(HOST_WDATA_OFF, 32'h1);
    run_op(OP_L1_WRITE, 8'd0, 3'h0);
    @(posedge aclk);
    `CHK(tx_cw_insert, 1'b1)
    tx_cw_num <= 8'd201;
    repeat (2) @(posedge aclk);
    `CHK(tx_cw_insert, 1'b0)
    `CHK(tx_cw_data, 136'h0)
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, rx_cw_valid} = 6'h0;
    {awaddr, araddr, wstrb} = 12'h00f;
    wdata_s = 32'h0;
    rx_cw_num = 8'h00;
    tx_cw_num = 8'h00;
    rx_cw_data = '0;
    line_rate = RATE_0614;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rx_rates();
    t_tx();
    results();
  end
endmodule
